// *** core/interrupt_flag_mask_unit.sv ***
// Interrupt request flags, masks, global enable and priority encoder
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps

// Summary of operation
// - External pin mask 0 passes its flag; 1 blocks it, flag still held
// - Timer A overflow sets its flag, bit 2 of word 0x001
// - Timer A mask at bit 3 of word 0x001, 1 blocks, 0 passes
// - Timer B overflow sets its flag, bit 0 of word 0x002
// - Timer B mask at bit 1 of word 0x002, 1 blocks, 0 passes
// - Timer C overflow sets its flag, bit 2 of word 0x002
// - Timer C mask at bit 3 of word 0x002, 1 blocks, 0 passes
// - Timer D flag, bit 0 of 0x003, set on overflow or capture pin edge
// - Timer D mask at bit 1 of word 0x003, 1 blocks, 0 passes
// - Serial flags at bit 2 set on transfer done
// - Serial masks at bit 3 of their words, 1 blocks, 0 passes
// - Global enable at word 0 bit 0; cleared on accept, set on return
// - Fixed priority one to seven, each level with its own vector
// - Pins 0,1 set on falling edge; pins 2-4 on selected edge
module interrupt_flag_mask_unit
    import irq_flag_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire reg_bus_t bus,
    output logic [DATA_W-1:0] bus_rdata,
    input wire periph_evt_t periph_evt,
    input wire logic capture_enable,
    input wire logic [N_PIN-1:0] ext_irq_pins,
    input wire logic capture_event_pin,
    input wire logic irq_accept,
    input wire logic return_from_irq_instr,
    output core_req_t irq_to_core,
    output logic sys_irq
);

    ctrl_state_t s_r;
    ctrl_state_t s_nxt;

    logic [N_CH-1:0] pin_raw;
    logic [N_CH-1:0][1:0] pin_edge_sel;
    logic [N_CH-1:0] pin_hit;

    // Word image of one address as software sees it
    function automatic logic [DATA_W-1:0] read_word(
        input logic [ADDR_W-1:0] addr,
        input ctrl_state_t st
    );
        logic [DATA_W-1:0] w;
        w = '0;
        for (int i = 0; i < N_SRC; i++)
        begin
            if (addr == SRC_ADDR[i])
            begin
                w[SRC_FBIT[i]] = st.flag[i];
                w[SRC_FBIT[i] + 1] = st.mask[i];
            end
        end
        if (addr == ADDR_IE_WORD)
        begin
            w[IE_BIT] = st.global_irq_enable;
        end
        if (addr == ADDR_EVT_STAT)
        begin
            w = DATA_W'(st.evt_stat);
        end
        if (addr == ADDR_EVT_EN)
        begin
            w = DATA_W'(st.evt_en);
        end
        return w;
    endfunction

    // Highest priority (lowest level number) among pending sources
    function automatic logic [PRIO_W-1:0] best_level(
        input logic [N_SRC-1:0] pending
    );
        logic [PRIO_W-1:0] lvl;
        lvl = PRIO_NONE;
        for (int i = 0; i < N_SRC; i++)
        begin
            if (pending[i] && (lvl == PRIO_NONE || SRC_PRIO[i] < lvl))
            begin
                lvl = SRC_PRIO[i];
            end
        end
        return lvl;
    endfunction

    // Pin channels: five external pins and the capture input
    always_comb
    begin
        pin_raw = {capture_event_pin, ext_irq_pins};
        pin_edge_sel[SRC_PIN0] = EDGE_FALL;
        pin_edge_sel[SRC_PIN1] = EDGE_FALL;
        pin_edge_sel[SRC_PIN2] = s_r.edge_select_word_a[1:0];
        pin_edge_sel[SRC_PIN3] = s_r.edge_select_word_a[3:2];
        pin_edge_sel[SRC_PIN4] = s_r.edge_select_word_b;
        pin_edge_sel[CH_CAPTURE] = capture_enable ? EDGE_BOTH : EDGE_NONE;
    end

    pin_edge_detect #(
        .WIDTH(N_CH)
    ) u_pin_edge (
        .core_clk(core_clk),
        .resetn(resetn),
        .pin_in(pin_raw),
        .edge_sel(pin_edge_sel),
        .edge_hit(pin_hit)
    );

    always_comb
    begin
        logic [N_SRC-1:0] set_req;
        logic [N_SRC-1:0] pending;
        logic [EVT_W-1:0] evt_set;
        set_req = '0;
        pending = '0;
        evt_set = '0;
        s_nxt = s_r;

        // Hardware request sources
        set_req[SRC_PIN0] = pin_hit[SRC_PIN0];
        set_req[SRC_PIN1] = pin_hit[SRC_PIN1];
        set_req[SRC_PIN2] = pin_hit[SRC_PIN2];
        set_req[SRC_PIN3] = pin_hit[SRC_PIN3];
        set_req[SRC_PIN4] = pin_hit[SRC_PIN4];
        set_req[SRC_TMRA] = periph_evt.tmra_ovf;
        set_req[SRC_TMRB] = periph_evt.tmrb_ovf;
        set_req[SRC_TMRC] = periph_evt.tmrc_ovf;
        set_req[SRC_TMRD] = periph_evt.tmrd_ovf | pin_hit[CH_CAPTURE];
        set_req[SRC_SER1] = periph_evt.serial_one_done;
        set_req[SRC_SER2] = periph_evt.serial_two_done;

        // Software writes
        if (bus.wr)
        begin
            for (int i = 0; i < N_SRC; i++)
            begin
                if (bus.addr == SRC_ADDR[i])
                begin
                    if (!bus.wdata[SRC_FBIT[i]])
                    begin
                        s_nxt.flag[i] = 1'b0;
                    end
                    s_nxt.mask[i] = bus.wdata[SRC_FBIT[i] + 1];
                end
            end
            unique case (bus.addr)
                ADDR_IE_WORD:
                begin
                    s_nxt.global_irq_enable = bus.wdata[IE_BIT];
                end
                ADDR_EDGE_SEL_A:
                begin
                    s_nxt.edge_select_word_a = bus.wdata[3:0];
                end
                ADDR_EDGE_SEL_B:
                begin
                    s_nxt.edge_select_word_b = bus.wdata[1:0];
                end
                ADDR_EVT_EN:
                begin
                    s_nxt.evt_en = bus.wdata[EVT_W-1:0];
                end
                ADDR_EVT_CLR:
                begin
                    s_nxt.evt_stat = s_r.evt_stat & ~bus.wdata[EVT_W-1:0];
                end
                default:
                begin
                end
            endcase
        end

        // Acceptance clears the enable, return sets it; return wins
        if (irq_accept)
        begin
            s_nxt.global_irq_enable = 1'b0;
        end
        if (return_from_irq_instr)
        begin
            s_nxt.global_irq_enable = 1'b1;
        end

        // New request lands after a clear in the same cycle; flags never auto-clear
        s_nxt.flag = s_nxt.flag | set_req;

        // Sticky events
        evt_set[EVT_ACCEPT] = irq_accept;
        evt_set[EVT_RETURN] = return_from_irq_instr;
        evt_set[EVT_OVERRUN] = |(set_req & s_r.flag);
        s_nxt.evt_stat = s_nxt.evt_stat | evt_set;
        s_nxt.sys_irq = |(s_nxt.evt_stat & s_nxt.evt_en);

        // Read data valid only in the cycle after the strobe
        if (bus.rd)
        begin
            s_nxt.rdata = read_word(bus.addr, s_r);
        end
        else
        begin
            s_nxt.rdata = '0;
        end

        // Request to the core from the next state of flags and masks
        pending = s_nxt.flag & ~s_nxt.mask;
        s_nxt.core.req = s_nxt.global_irq_enable & (|pending);
        s_nxt.core.level = best_level(pending);
        s_nxt.core.vector = VEC_W'(s_nxt.core.level) * VEC_STEP;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r.global_irq_enable <= IE_RST;
            s_r.flag <= FLAG_RST;
            s_r.mask <= MASK_RST;
            s_r.edge_select_word_a <= EDGE_SEL_A_RST;
            s_r.edge_select_word_b <= EDGE_SEL_B_RST;
            s_r.evt_stat <= EVT_RST;
            s_r.evt_en <= EVT_RST;
            s_r.rdata <= '0;
            s_r.sys_irq <= 1'b0;
            s_r.core <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign bus_rdata = s_r.rdata;
    assign irq_to_core = s_r.core;
    assign sys_irq = s_r.sys_irq;

endmodule // interrupt_flag_mask_unit

// *** core/irq_flag_pkg.sv ***
// Shared constants, types and register map of the interrupt flag and mask unit
package irq_flag_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 4;
    localparam int N_SRC = 11;
    localparam int N_PIN = 5;
    localparam int N_CH = 6;
    localparam int PRIO_W = 3;
    localparam int VEC_W = 14;
    localparam int EVT_W = 3;

    // Word addresses
    localparam logic [ADDR_W-1:0] ADDR_IE_WORD = 6'h00;
    localparam logic [ADDR_W-1:0] ADDR_TMRA_WORD = 6'h01;
    localparam logic [ADDR_W-1:0] ADDR_TMRBC_WORD = 6'h02;
    localparam logic [ADDR_W-1:0] ADDR_TMRD_SER1_WORD = 6'h03;
    localparam logic [ADDR_W-1:0] ADDR_PIN23_WORD = 6'h22;
    localparam logic [ADDR_W-1:0] ADDR_SER2_WORD = 6'h23;
    localparam logic [ADDR_W-1:0] ADDR_EDGE_SEL_A = 6'h26;
    localparam logic [ADDR_W-1:0] ADDR_EDGE_SEL_B = 6'h27;
    localparam logic [ADDR_W-1:0] ADDR_EVT_STAT = 6'h30;
    localparam logic [ADDR_W-1:0] ADDR_EVT_EN = 6'h31;
    localparam logic [ADDR_W-1:0] ADDR_EVT_CLR = 6'h32;

    // Source indices
    localparam int SRC_PIN0 = 0;
    localparam int SRC_PIN1 = 1;
    localparam int SRC_PIN2 = 2;
    localparam int SRC_PIN3 = 3;
    localparam int SRC_PIN4 = 4;
    localparam int SRC_TMRA = 5;
    localparam int SRC_TMRB = 6;
    localparam int SRC_TMRC = 7;
    localparam int SRC_TMRD = 8;
    localparam int SRC_SER1 = 9;
    localparam int SRC_SER2 = 10;
    localparam int CH_CAPTURE = 5;

    // Word and flag bit of each source; its mask sits one bit above
    localparam logic [ADDR_W-1:0] SRC_ADDR [N_SRC] = '{6'h00, 6'h01, 6'h22, 6'h22, 6'h23,
        6'h01, 6'h02, 6'h02, 6'h03, 6'h03, 6'h23};
    localparam int SRC_FBIT [N_SRC] = '{2, 0, 0, 2, 0, 2, 0, 2, 0, 2, 2};
    localparam logic [PRIO_W-1:0] SRC_PRIO [N_SRC] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6,
        3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h7};
    localparam int IE_BIT = 0;
    localparam logic [PRIO_W-1:0] PRIO_NONE = 3'h0;
    localparam logic [VEC_W-1:0] VEC_STEP = 14'h0002;

    // Reset values
    localparam logic IE_RST = 1'h0;
    localparam logic [N_SRC-1:0] FLAG_RST = 11'h000;
    localparam logic [N_SRC-1:0] MASK_RST = 11'h7ff;
    localparam logic [3:0] EDGE_SEL_A_RST = 4'h0;
    localparam logic [1:0] EDGE_SEL_B_RST = 2'h0;
    localparam logic [EVT_W-1:0] EVT_RST = 3'h0;

    // Sticky event bits
    localparam int EVT_ACCEPT = 0;
    localparam int EVT_RETURN = 1;
    localparam int EVT_OVERRUN = 2;

    typedef enum logic [1:0] {EDGE_NONE, EDGE_FALL, EDGE_RISE, EDGE_BOTH} edge_sel_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_bus_t;

    typedef struct packed {
        logic tmra_ovf;
        logic tmrb_ovf;
        logic tmrc_ovf;
        logic tmrd_ovf;
        logic serial_one_done;
        logic serial_two_done;
    } periph_evt_t;

    typedef struct packed {
        logic req;
        logic [PRIO_W-1:0] level;
        logic [VEC_W-1:0] vector;
    } core_req_t;

    typedef struct packed {
        logic global_irq_enable;
        logic [N_SRC-1:0] flag;
        logic [N_SRC-1:0] mask;
        logic [3:0] edge_select_word_a;
        logic [1:0] edge_select_word_b;
        logic [EVT_W-1:0] evt_stat;
        logic [EVT_W-1:0] evt_en;
        logic [DATA_W-1:0] rdata;
        logic sys_irq;
        core_req_t core;
    } ctrl_state_t;

endpackage

// *** core/pin_edge_detect.sv ***
// Pin synchroniser and selectable edge detector
`timescale 1ns/10ps

module pin_edge_detect
    import irq_flag_pkg::*;
#(
    parameter int WIDTH = N_CH
)
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] pin_in,
    input wire logic [WIDTH-1:0][1:0] edge_sel,
    output logic [WIDTH-1:0] edge_hit
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
        logic [WIDTH-1:0] hit;
        logic [2:0] warm;
    } edge_state_t;

    edge_state_t s_r;
    edge_state_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.meta = pin_in;
        s_nxt.sync = s_r.meta;
        s_nxt.prev = s_r.sync;
        // No edge until the pin history is filled after reset
        s_nxt.warm = {s_r.warm[1:0], 1'b1};
        for (int i = 0; i < WIDTH; i++)
        begin
            s_nxt.hit[i] = s_r.warm[2] & ((edge_sel[i][0] & s_r.prev[i] & ~s_r.sync[i])
                | (edge_sel[i][1] & ~s_r.prev[i] & s_r.sync[i]));
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign edge_hit = s_r.hit;

endmodule // pin_edge_detect

// *** test/irq_unit_assertions.sv ***
// Port checker for the interrupt flag and mask unit
`timescale 1ns/10ps
module irq_unit_checker
    import irq_flag_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire reg_bus_t bus,
    input wire logic [DATA_W-1:0] bus_rdata,
    input wire logic irq_accept,
    input wire logic return_from_irq_instr,
    input wire core_req_t irq_to_core,
    input wire logic sys_irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_rdata_idle: assert property (!$past(bus.rd) |-> bus_rdata == 4'h0)
        else $error("read data outside read cycle");
    a_rdata_wo: assert property ($past(bus.rd) && ($past(bus.addr) inside {6'h26, 6'h27, 6'h32, 6'h3f})
        |-> bus_rdata == 4'h0) else $error("write-only or unmapped word read nonzero");
    a_vec_level: assert property (irq_to_core.req |-> irq_to_core.vector == {11'h0, irq_to_core.level} << 1)
        else $error("vector does not match level");
    a_level_nonzero: assert property (irq_to_core.req |-> irq_to_core.level != 3'h0)
        else $error("request without level");
    a_accept_drop: assert property (irq_accept && !return_from_irq_instr |=> !irq_to_core.req)
        else $error("request stays after accept");
    a_accept_hold: assert property (irq_accept && !return_from_irq_instr ##1
        (!bus.wr && !return_from_irq_instr)[*3] |=> !irq_to_core.req) else $error("request back without return");
    a_req_fall: assert property ($fell(irq_to_core.req) |-> $past(irq_accept || bus.wr))
        else $error("request dropped by itself");
    a_sys_fall: assert property ($fell(sys_irq) |-> $past(bus.wr))
        else $error("event interrupt dropped by itself");
endmodule // irq_unit_checker

bind interrupt_flag_mask_unit irq_unit_checker irq_unit_checker_inst (.core_clk, .resetn, .bus, .bus_rdata,
    .irq_accept, .return_from_irq_instr, .irq_to_core, .sys_irq);

// *** test/core_model.sv ***
// Processor core model that takes an interrupt after a set delay
`timescale 1ns/10ps
module core_model
    import irq_flag_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire core_req_t irq_to_core,
    input wire logic take_en,
    input wire logic [3:0] delay,
    output logic irq_accept
);
    logic [3:0] wait_r;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wait_r <= 4'h0;
            irq_accept <= 1'b0;
        end
        else
        begin
            irq_accept <= 1'b0;
            if (!take_en || !irq_to_core.req || irq_accept)
                wait_r <= 4'h0;
            else if (wait_r == delay)
                irq_accept <= 1'b1;
            else
                wait_r <= wait_r + 4'h1;
        end
    end
endmodule // core_model

// *** test/test_interrupt_flag_mask_unit.sv ***
// Self-checking bench of the interrupt flag and mask unit
`timescale 1ns/10ps
module test_interrupt_flag_mask_unit
    import irq_flag_pkg::*;
;
    logic core_clk, resetn, capture_enable, capture_event_pin, ret, take_en, irq_accept, sys_irq;
    logic [3:0] delay, bus_rdata;
    logic [N_PIN-1:0] pins;
    reg_bus_t bus;
    periph_evt_t pe;
    core_req_t rq;
    int bad_count, comparisons, cyc;
    interrupt_flag_mask_unit interrupt_flag_mask_unit_inst (.core_clk, .resetn, .bus, .bus_rdata,
        .periph_evt(pe), .capture_enable, .ext_irq_pins(pins), .capture_event_pin, .irq_accept,
        .return_from_irq_instr(ret), .irq_to_core(rq), .sys_irq);
    core_model core_model_inst (.core_clk, .resetn, .irq_to_core(rq), .take_en, .delay, .irq_accept);
    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        if (bad_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr(logic [5:0] a, logic [3:0] d);
        @(posedge core_clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(logic [5:0] a, logic [3:0] e);
        @(posedge core_clk);
        bus <= '{a, 4'h0, 1'b0, 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1;
        chk(16'(bus_rdata), 16'(e));
    endtask
    task automatic pulse(logic [5:0] v);
        @(posedge core_clk);
        pe <= v;
        @(posedge core_clk);
        pe <= '0;
        #1;
    endtask
    task automatic t_reset;
        rd(ADDR_IE_WORD, 4'h8);
        rd(ADDR_TMRA_WORD, 4'ha);
        rd(ADDR_TMRBC_WORD, 4'ha);
        rd(ADDR_TMRD_SER1_WORD, 4'ha);
        rd(ADDR_SER2_WORD, 4'ha);
        rd(6'h3f, 4'h0);
    endtask
    task automatic t_sources;
        logic [5:0] a [6] = '{6'h01, 6'h02, 6'h02, 6'h03, 6'h03, 6'h23};
        logic [3:0] f [6] = '{4'h4, 4'h1, 4'h4, 4'h1, 4'h4, 4'h4};
        logic [2:0] l [6] = '{3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h7};
        wr(ADDR_IE_WORD, 4'h1);
        for (int i = 0; i < 6; i++)
        begin
            pulse(6'h20 >> i);
            chk(rq.req, 1'b0);
            wr(a[i], 4'h5);
            rd(a[i], f[i]);
            chk(rq.level, l[i]);
            wr(a[i], 4'ha);
            rd(a[i], 4'ha);
            chk(rq.req, 1'b0);
        end
    endtask
    task automatic t_prio;
        wr(ADDR_TMRA_WORD, 4'h5);
        wr(ADDR_TMRD_SER1_WORD, 4'h5);
        pulse(6'h22);
        chk(rq.vector, 14'h0006);
        wr(ADDR_TMRA_WORD, 4'ha);
        rd(ADDR_TMRA_WORD, 4'ha);
        chk(rq.vector, 14'h000e);
    endtask
    task automatic t_accept;
        wr(ADDR_EVT_EN, 4'h1);
        @(posedge core_clk);
        take_en <= 1'b1;
        for (int n = 0; n < 20 && irq_accept !== 1'b1; n++)
        begin
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        take_en <= 1'b0;
        #1;
        chk(rq.req, 1'b0);
        chk(sys_irq, 1'b1);
        rd(ADDR_IE_WORD, 4'h0);
        rd(ADDR_TMRD_SER1_WORD, 4'h4);
        rd(ADDR_EVT_STAT, 4'h1);
        pulse(6'h02);
        rd(ADDR_EVT_STAT, 4'h5);
        wr(ADDR_EVT_EN, 4'h0);
        rd(ADDR_EVT_CLR, 4'h0);
        chk(sys_irq, 1'b0);
        wr(ADDR_EVT_CLR, 4'h7);
        rd(ADDR_EVT_STAT, 4'h0);
        @(posedge core_clk);
        ret <= 1'b1;
        @(posedge core_clk);
        ret <= 1'b0;
        rd(ADDR_IE_WORD, 4'h1);
        chk(rq.level, 3'h7);
        rd(ADDR_EVT_STAT, 4'h2);
        @(posedge core_clk);
        bus <= '{ADDR_TMRD_SER1_WORD, 4'ha, 1'b1, 1'b0};
        pe <= 6'h02;
        @(posedge core_clk);
        bus.wr <= 1'b0;
        pe <= '0;
        rd(ADDR_TMRD_SER1_WORD, 4'he);
        wr(ADDR_TMRD_SER1_WORD, 4'ha);
    endtask
    task automatic t_pins;
        wr(ADDR_EDGE_SEL_A, 4'h6);
        wr(ADDR_EDGE_SEL_B, 4'h3);
        capture_enable <= 1'b1;
        @(posedge core_clk);
        pins <= 5'h14;
        capture_event_pin <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(ADDR_TMRA_WORD, 4'hb);
        rd(ADDR_PIN23_WORD, 4'hf);
        rd(ADDR_SER2_WORD, 4'hb);
        rd(ADDR_TMRD_SER1_WORD, 4'hb);
        rd(ADDR_IE_WORD, 4'h5);
        chk(rq.level, 3'h1);
        wr(ADDR_PIN23_WORD, 4'ha);
        wr(ADDR_SER2_WORD, 4'ha);
        pins <= 5'h0b;
        repeat (6) @(posedge core_clk);
        rd(ADDR_PIN23_WORD, 4'ha);
        rd(ADDR_SER2_WORD, 4'hb);
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            bad_count++;
            summarize;
        end
    end
    initial
    begin
        {resetn, capture_enable, capture_event_pin, ret, take_en} = '0;
        bus = '0;
        pe = '0;
        pins = 5'h0b;
        delay = 4'h3;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset;
        t_sources;
        t_prio;
        t_accept;
        t_pins;
        summarize;
    end
endmodule // test_interrupt_flag_mask_unit
